// >>> hw/ssf_pkg.sv
// Purpose: shared constants for the serial status flag block
// Assumes: 32-bit apb, one word per register
// Notes:   flag and enable registers share one bit layout

// ****************************************
// constants
// ****************************************
package ssf_pkg;

    localparam int          APB_AW          = 12;
    localparam int          APB_DW          = 32;
    localparam int          REG_W           = 8;

    localparam logic [11:0] OFS_FLAGS       = 12'h000;
    localparam logic [11:0] OFS_ENABLES     = 12'h004;
    localparam logic [11:0] OFS_CONTROL     = 12'h008;

    localparam int          BIT_SHIFT_EMPTY = 7;
    localparam int          BIT_COUNT_ZERO  = 6;
    localparam int          BIT_SEL_START   = 5;
    localparam int          BIT_SEL_END     = 4;
    localparam int          BIT_RX_OVER     = 2;
    localparam int          BIT_TX_UNDER    = 1;

    localparam int          BIT_MASTER      = 0;
    localparam int          BIT_TX_REQ      = 1;
    localparam int          BIT_RX_REQ      = 2;

    localparam logic [7:0]  IMPL_MASK       = 8'hf6;
    localparam logic [7:0]  CTRL_MASK       = 8'h07;

    localparam logic [7:0]  RST_FLAGS       = 8'h00;
    localparam logic [7:0]  RST_ENABLES     = 8'h00;
    localparam logic [7:0]  RST_CONTROL     = 8'h00;

    localparam logic        SEL_IDLE        = 1'b0;

    typedef logic [7:0] ssf_byte_t;

endpackage : ssf_pkg

// >>> hw/ssf_evt_if.sv
// Purpose: carries event strobes from the detector to the register block
// Assumes: single pclk domain
// Notes:   all signals are one-cycle pulses

`timescale 1ns/1ps

// ****************************************
// interface
// ****************************************
interface ssf_evt_if;
    import ssf_pkg::*;

    ssf_byte_t set_vec;
    logic      rx_discard;
    logic      tx_replay;

    modport src (output set_vec, output rx_discard, output tx_replay);
    modport dst (input  set_vec, input  rx_discard, input  tx_replay);

endinterface : ssf_evt_if

// >>> hw/ssf_evt_detect.sv
// Purpose: turns shift engine events into flag set strobes
// Assumes: all inputs come from logic on pclk
// Notes:   select edges are found against the previous effective level

`timescale 1ns/1ps

module ssf_evt_detect
    import ssf_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic master_mode,
    input  wire logic tx_data_required,
    input  wire logic rx_space_required,
    input  wire logic xfer_done,
    input  wire logic xfer_start,
    input  wire logic start_pending,
    input  wire logic count_hit_zero,
    input  wire logic ss_active,
    input  wire logic rx_buffer_full,
    input  wire logic tx_buffer_empty,
    ssf_evt_if.src    evt
);

    // ****************************************
    // select edge history
    // ****************************************
    logic sel_prev_ff;
    logic rx_over;
    logic tx_under;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sel_prev_ff <= SEL_IDLE;
        else
            sel_prev_ff <= ss_active;
    end

    // ****************************************
    // set strobes
    // ****************************************
    // overflow and underflow cannot happen when this end drives the clock
    assign rx_over  = !master_mode && xfer_done && rx_buffer_full && rx_space_required;
    assign tx_under = !master_mode && xfer_start && tx_buffer_empty && tx_data_required;

    always_comb
    begin
        evt.set_vec                  = 8'h00;
        evt.set_vec[BIT_SHIFT_EMPTY] = master_mode && xfer_done && !start_pending;
        evt.set_vec[BIT_COUNT_ZERO]  = count_hit_zero;
        evt.set_vec[BIT_SEL_START]   = ss_active && !sel_prev_ff;
        evt.set_vec[BIT_SEL_END]     = !ss_active && sel_prev_ff;
        evt.set_vec[BIT_RX_OVER]     = rx_over;
        evt.set_vec[BIT_TX_UNDER]    = tx_under;
    end

    assign evt.rx_discard = rx_over;
    assign evt.tx_replay  = tx_under;

    // ****************************************
    // checks
    // ****************************************
    sel_edges_a : assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ss_active) |-> evt.set_vec[BIT_SEL_START] && !evt.set_vec[BIT_SEL_END])
        else $error("select start not strobed on rising select");

    empty_slave_a : assert property (@(posedge pclk) disable iff (!presetn)
        !master_mode |-> !evt.set_vec[BIT_SHIFT_EMPTY])
        else $error("shifter empty strobed in slave mode");

endmodule : ssf_evt_detect

// >>> hw/ssf_top.sv
// Purpose: status event flags, enables and interrupt request over apb
// Assumes: event inputs are pclk-synchronous pulses or levels
// Notes:   zero-wait apb slave answering in the first access cycle
//
// How it works
// - master mode, finished transfer with nothing queued sets shifter empty flag.
// - transfer counter reaching zero sets the count zero flag.
// - effective select going inactive to active sets select start flag.
// - effective select going active to inactive sets select end flag.
// - slave transfer done with receive full and space required sets overflow.
// - slave transfer start with transmit empty and data required sets underflow.
// - all six flags set by hardware, read and write by software, reset zero.
// - one enable bit per flag position, read write, reset zero.
// - bits three and zero of both registers always read zero.
// - interrupt request high while any flag and its enable are both set.
// - overflow discards the new word; underflow replays last received word.
// - flags never clear themselves when the cause goes away.

`timescale 1ns/1ps

module ssf_top
    import ssf_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [APB_DW-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [APB_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              xfer_done,
    input  wire logic              xfer_start,
    input  wire logic              start_pending,
    input  wire logic              count_hit_zero,
    input  wire logic              ss_active,
    input  wire logic              rx_buffer_full,
    input  wire logic              tx_buffer_empty,
    output logic                   module_irq_request,
    output logic                   master_mode,
    output logic                   tx_data_required,
    output logic                   rx_space_required,
    output logic                   rx_word_discard,
    output logic                   tx_replay_last_rx
);

    // ****************************************
    // declarations
    // ****************************************
    ssf_byte_t         flags_ff;
    ssf_byte_t         nxt_flags;
    ssf_byte_t         enables_ff;
    ssf_byte_t         control_ff;
    logic [APB_DW-1:0] prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              irq_ff;
    logic              discard_ff;
    logic              replay_ff;
    logic              setup_phase;
    logic              access_done;
    logic              wr_lane0;
    logic              wr_flags;
    logic              wr_enables;
    logic              wr_control;

    ssf_evt_if evt ();

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic is_mapped(input logic [APB_AW-1:0] a);
        is_mapped = (a == OFS_FLAGS) || (a == OFS_ENABLES) || (a == OFS_CONTROL);
    endfunction : is_mapped

    function automatic ssf_byte_t read_mux(input logic [APB_AW-1:0] a,
                                           input ssf_byte_t        f,
                                           input ssf_byte_t        e,
                                           input ssf_byte_t        c);
        read_mux = 8'h00;
        case (a)
            OFS_FLAGS   : read_mux = f & IMPL_MASK;
            OFS_ENABLES : read_mux = e & IMPL_MASK;
            OFS_CONTROL : read_mux = c & CTRL_MASK;
            default     : read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // only byte lane 0 carries register bits; other lanes are ignored
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_ff;
    assign wr_lane0    = access_done && pwrite && pstrb[0];
    assign wr_flags    = wr_lane0 && (paddr == OFS_FLAGS);
    assign wr_enables  = wr_lane0 && (paddr == OFS_ENABLES);
    assign wr_control  = wr_lane0 && (paddr == OFS_CONTROL);

    // ****************************************
    // apb handshake
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_ff <= 1'b0;
        else
            pready_ff <= setup_phase;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_ff <= 1'b0;
        else if (setup_phase)
            pslverr_ff <= !is_mapped(paddr);
        else
            pslverr_ff <= 1'b0;
    end

    // read data is caught in the setup cycle so prdata can be a flop;
    // a flag set in that same cycle shows on the next read, never lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= '0;
        else if (setup_phase && !pwrite)
            prdata_ff <= {24'h000000, read_mux(paddr, flags_ff, enables_ff, control_ff)};
        else if (access_done)
            prdata_ff <= '0;
    end

    // ****************************************
    // event detector
    // ****************************************
    ssf_evt_detect u_evt (
        .pclk              (pclk),
        .presetn           (presetn),
        .master_mode       (control_ff[BIT_MASTER]),
        .tx_data_required  (control_ff[BIT_TX_REQ]),
        .rx_space_required (control_ff[BIT_RX_REQ]),
        .xfer_done         (xfer_done),
        .xfer_start        (xfer_start),
        .start_pending     (start_pending),
        .count_hit_zero    (count_hit_zero),
        .ss_active         (ss_active),
        .rx_buffer_full    (rx_buffer_full),
        .tx_buffer_empty   (tx_buffer_empty),
        .evt               (evt.src)
    );

    // ****************************************
    // flag register
    // ****************************************
    always_comb
    begin
        nxt_flags = flags_ff;
        if (wr_flags)
            nxt_flags = pwdata[REG_W-1:0] & IMPL_MASK;
        nxt_flags = (nxt_flags | evt.set_vec) & IMPL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= RST_FLAGS;
        else
            flags_ff <= nxt_flags;
    end

    // ****************************************
    // enable and control registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enables_ff <= RST_ENABLES;
        else if (wr_enables)
            enables_ff <= pwdata[REG_W-1:0] & IMPL_MASK;
    end

    // mode bits should only change while the shift engine is idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_ff <= RST_CONTROL;
        else if (wr_control)
            control_ff <= pwdata[REG_W-1:0] & CTRL_MASK;
    end

    // ****************************************
    // interrupt and data-path strobes
    // ****************************************
    // one cycle of latency keeps the request a clean flop output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(flags_ff & enables_ff);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            discard_ff <= 1'b0;
        else
            discard_ff <= evt.rx_discard;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            replay_ff <= 1'b0;
        else
            replay_ff <= evt.tx_replay;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign module_irq_request = irq_ff;
    assign master_mode        = control_ff[BIT_MASTER];
    assign tx_data_required   = control_ff[BIT_TX_REQ];
    assign rx_space_required  = control_ff[BIT_RX_REQ];
    assign rx_word_discard    = discard_ff;
    assign tx_replay_last_rx  = replay_ff;

    // ****************************************
    // checks
    // ****************************************
    shifter_set_a : assert property (@(posedge pclk) disable iff (!presetn)
        control_ff[BIT_MASTER] && xfer_done && !start_pending
        |=> flags_ff[BIT_SHIFT_EMPTY])
        else $error("shifter empty flag not set after transfer");

    count_set_a : assert property (@(posedge pclk) disable iff (!presetn)
        count_hit_zero |=> flags_ff[BIT_COUNT_ZERO])
        else $error("count zero flag not set");

    sel_start_a : assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ss_active) |=> flags_ff[BIT_SEL_START])
        else $error("select start flag not set");

    sel_end_a : assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ss_active) |=> flags_ff[BIT_SEL_END])
        else $error("select end flag not set");

    rx_over_a : assert property (@(posedge pclk) disable iff (!presetn)
        !control_ff[BIT_MASTER] && control_ff[BIT_RX_REQ] && xfer_done && rx_buffer_full
        |=> flags_ff[BIT_RX_OVER] && rx_word_discard)
        else $error("overflow not flagged or word not discarded");

    tx_under_a : assert property (@(posedge pclk) disable iff (!presetn)
        !control_ff[BIT_MASTER] && control_ff[BIT_TX_REQ] && xfer_start && tx_buffer_empty
        |=> flags_ff[BIT_TX_UNDER] && tx_replay_last_rx)
        else $error("underflow not flagged or replay missing");

    master_no_over_a : assert property (@(posedge pclk) disable iff (!presetn)
        control_ff[BIT_MASTER] |=> !rx_word_discard && !tx_replay_last_rx)
        else $error("slave-only strobe seen in master mode");

    enable_write_a : assert property (@(posedge pclk) disable iff (!presetn)
        wr_enables |=> enables_ff == ($past(pwdata[REG_W-1:0]) & IMPL_MASK))
        else $error("enable register write lost");

    unimpl_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff & ~IMPL_MASK) == 8'h00 && (enables_ff & ~IMPL_MASK) == 8'h00)
        else $error("unimplemented bit reads one");

    irq_level_a : assert property (@(posedge pclk) disable iff (!presetn)
        ##1 module_irq_request == |($past(flags_ff) & $past(enables_ff)))
        else $error("interrupt request does not follow flags and enables");

    sticky_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
        flags_ff[BIT_SEL_START] && !wr_flags |=> flags_ff[BIT_SEL_START])
        else $error("flag cleared without software write");

    clear_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
        wr_flags && !pwdata[BIT_COUNT_ZERO] && !count_hit_zero
        |=> !flags_ff[BIT_COUNT_ZERO])
        else $error("write of zero did not clear flag");

    set_wins_a : assert property (@(posedge pclk) disable iff (!presetn)
        wr_flags && count_hit_zero |=> flags_ff[BIT_COUNT_ZERO])
        else $error("hardware set lost against software clear");

    apb_answer_a : assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    unmapped_err_a : assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !is_mapped(paddr) |=> pslverr)
        else $error("unmapped access not answered with error");

    rdata_idle_a : assert property (@(posedge pclk) disable iff (!presetn)
        !psel |-> prdata == '0)
        else $error("read data not zero outside a transfer");

    read_flags_a : assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == OFS_FLAGS
        |=> prdata == {24'h000000, $past(flags_ff)} && !prdata[3] && !prdata[0])
        else $error("flag read data wrong");

    flag_write_a : assert property (@(posedge pclk) disable iff (!presetn)
        wr_flags && evt.set_vec == 8'h00
        |=> flags_ff == ($past(pwdata[REG_W-1:0]) & IMPL_MASK))
        else $error("flag register write lost");

    slave_no_empty_a : assert property (@(posedge pclk) disable iff (!presetn)
        !control_ff[BIT_MASTER] && !flags_ff[BIT_SHIFT_EMPTY] && !wr_flags
        |=> !flags_ff[BIT_SHIFT_EMPTY])
        else $error("shifter empty flag set in slave mode");

    // the first edge after reset compares against the reset history, not the pin
    sel_quiet_a : assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && $stable(ss_active) && !flags_ff[BIT_SEL_START] && !wr_flags
        |=> !flags_ff[BIT_SEL_START])
        else $error("select start flag set without an edge");

    enables_off_a : assert property (@(posedge pclk) disable iff (!presetn)
        enables_ff == 8'h00 |=> !module_irq_request)
        else $error("interrupt request with all enables off");

    discard_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
        rx_word_discard |-> flags_ff[BIT_RX_OVER])
        else $error("word discarded without overflow flag");

    replay_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
        tx_replay_last_rx |-> flags_ff[BIT_TX_UNDER])
        else $error("replay without underflow flag");

    // every implemented flag stays set until software writes the register
    for (genvar g = 0; g < REG_W; g++)
    begin : g_hold
        if (IMPL_MASK[g])
        begin : g_impl
            flag_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
                flags_ff[g] && !wr_flags |=> flags_ff[g])
                else $error("flag cleared without software write");
        end
    end

endmodule : ssf_top

// >>> tb/ssf_engine_model.sv
// Purpose: stand-in for the shift engine that feeds the event lines
// Assumes: every line changes just after a pclk rising edge
// Notes:   pulses last one cycle; levels hold until changed

`timescale 1ns/1ps

// ****************************************
// engine model
// ****************************************
module ssf_engine_model
(
    input  wire logic pclk,
    output logic      xfer_done,
    output logic      xfer_start,
    output logic      start_pending,
    output logic      count_hit_zero,
    output logic      ss_active,
    output logic      rx_buffer_full,
    output logic      tx_buffer_empty
);
    initial
    begin
        xfer_done       = 1'b0;
        xfer_start      = 1'b0;
        start_pending   = 1'b0;
        count_hit_zero  = 1'b0;
        ss_active       = 1'b0;
        rx_buffer_full  = 1'b0;
        tx_buffer_empty = 1'b0;
    end

    // levels are moved together so one edge sees a consistent picture
    task automatic set_lvl(input logic ss, input logic rxf, input logic txe, input logic pend);
        @(posedge pclk);
        ss_active       <= ss;
        rx_buffer_full  <= rxf;
        tx_buffer_empty <= txe;
        start_pending   <= pend;
    endtask : set_lvl

    task automatic pulse(input logic done, input logic start, input logic cz);
        @(posedge pclk);
        xfer_done      <= done;
        xfer_start     <= start;
        count_hit_zero <= cz;
        @(posedge pclk);
        xfer_done      <= 1'b0;
        xfer_start     <= 1'b0;
        count_hit_zero <= 1'b0;
    endtask : pulse

endmodule : ssf_engine_model

// >>> tb/ssf_top_tb_top.sv
// Purpose: self-checking bench for the status flag block
// Assumes: zero-wait apb slave, master waits on pready anyway
// Notes:   read results are checked from a queue by a monitor

`timescale 1ns/1ps

// ****************************************
// bench top
// ****************************************
module ssf_top_tb_top
    import ssf_pkg::*;
;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        xfer_done, xfer_start, start_pending, count_hit_zero;
    logic        ss_active, rx_buffer_full, tx_buffer_empty;
    logic        module_irq_request, master_mode, tx_data_required;
    logic        rx_space_required, rx_word_discard, tx_replay_last_rx;
    int          fails      = 0;
    int          num_checks = 0;
    int          n_disc     = 0;
    int          n_rep      = 0;
    logic [32:0] exp_q[$];

    always #5 pclk = ~pclk;

    ssf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_done(xfer_done), .xfer_start(xfer_start),
        .start_pending(start_pending), .count_hit_zero(count_hit_zero),
        .ss_active(ss_active), .rx_buffer_full(rx_buffer_full),
        .tx_buffer_empty(tx_buffer_empty), .module_irq_request(module_irq_request),
        .master_mode(master_mode), .tx_data_required(tx_data_required),
        .rx_space_required(rx_space_required), .rx_word_discard(rx_word_discard),
        .tx_replay_last_rx(tx_replay_last_rx));

    ssf_engine_model eng_u (.pclk(pclk), .xfer_done(xfer_done), .xfer_start(xfer_start),
        .start_pending(start_pending), .count_hit_zero(count_hit_zero),
        .ss_active(ss_active), .rx_buffer_full(rx_buffer_full),
        .tx_buffer_empty(tx_buffer_empty));

    // ****************************************
    // monitor
    // ****************************************
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            num_checks++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0])
            begin
                fails++;
                $display("[FAIL] %0t read at %h gave %h", $time, paddr, prdata);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
        if (rx_word_discard === 1'b1)
            n_disc++;
        if (tx_replay_last_rx === 1'b1)
            n_rep++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic bad(input string m);
        fails++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : bad

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // bounded wait: a missing pready ends the run
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16)
        begin
            bad("no pready");
            report_and_stop();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
            bad("output value differs");
    endtask : chk

    task automatic wait_irq(input logic e);
        int i;
        num_checks++;
        for (i = 0; i < 8 && module_irq_request !== e; i++)
            @(negedge pclk);
        if (module_irq_request !== e)
        begin
            bad("irq level wrong");
            report_and_stop();
        end
    endtask : wait_irq

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] r;
        int         k;
        k = $urandom(32'h5f8c);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_FLAGS, 32'h0, 1'b0);
        rd(OFS_ENABLES, 32'h0, 1'b0);
        rd(OFS_CONTROL, 32'h0, 1'b0);
        chk(module_irq_request, 1'b0);
        $display("test reset done");
        for (k = 0; k < 4; k++)
        begin
            r = (k == 0) ? 8'hff : 8'($urandom);
            wr(OFS_FLAGS, {24'h0, r});
            rd(OFS_FLAGS, {24'h0, r & 8'hf6}, 1'b0);
            wr(OFS_ENABLES, {24'h0, ~r});
            rd(OFS_ENABLES, {24'h0, ~r & 8'hf6}, 1'b0);
            chk(module_irq_request, 1'b0);
        end
        wr(OFS_ENABLES, 32'h40);
        wr(OFS_FLAGS, 32'h40);
        wait_irq(1'b1);
        wr(OFS_FLAGS, 32'h0);
        wait_irq(1'b0);
        apb(1'b1, 12'h00c, 32'hff, 4'hf);
        rd(12'h00c, 32'h0, 1'b1);
        apb(1'b1, OFS_ENABLES, 32'hff, 4'he);
        rd(OFS_ENABLES, 32'h40, 1'b0);
        $display("test register access done");
        wr(OFS_ENABLES, 32'hf6);
        wr(OFS_CONTROL, 32'h07);
        rd(OFS_CONTROL, 32'h07, 1'b0);
        chk({rx_space_required, tx_data_required, master_mode}, 3'b111);
        eng_u.set_lvl(1'b0, 1'b1, 1'b1, 1'b1);
        eng_u.pulse(1'b1, 1'b1, 1'b0);
        rd(OFS_FLAGS, 32'h0, 1'b0);
        eng_u.set_lvl(1'b0, 1'b1, 1'b1, 1'b0);
        eng_u.pulse(1'b1, 1'b0, 1'b0);
        rd(OFS_FLAGS, 32'h80, 1'b0);
        eng_u.pulse(1'b0, 1'b0, 1'b1);
        rd(OFS_FLAGS, 32'hc0, 1'b0);
        eng_u.set_lvl(1'b1, 1'b0, 1'b0, 1'b0);
        rd(OFS_FLAGS, 32'he0, 1'b0);
        eng_u.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFS_FLAGS, 32'hf0, 1'b0);
        wait_irq(1'b1);
        wr(OFS_ENABLES, 32'h0);
        wait_irq(1'b0);
        rd(OFS_FLAGS, 32'hf0, 1'b0);
        $display("test master events done");
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_CONTROL, 32'h06);
        eng_u.set_lvl(1'b0, 1'b1, 1'b1, 1'b0);
        eng_u.pulse(1'b1, 1'b0, 1'b0);
        rd(OFS_FLAGS, 32'h04, 1'b0);
        eng_u.pulse(1'b0, 1'b1, 1'b0);
        rd(OFS_FLAGS, 32'h06, 1'b0);
        chk(n_disc, 1);
        chk(n_rep, 1);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_FLAGS, 32'h0);
        eng_u.pulse(1'b1, 1'b1, 1'b0);
        rd(OFS_FLAGS, 32'h0, 1'b0);
        chk(n_disc + n_rep, 2);
        $display("test slave events done");
        // the count pulse lands on the very edge that commits the clearing write
        wr(OFS_FLAGS, 32'h06);
        fork
            wr(OFS_FLAGS, 32'h0);
            begin
                @(posedge pclk);
                eng_u.pulse(1'b0, 1'b0, 1'b1);
            end
        join
        rd(OFS_FLAGS, 32'h40, 1'b0);
        $display("test set priority done");
        // a second reset in mid-run must clear flags and enables again
        wr(OFS_ENABLES, 32'h40);
        wait_irq(1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_FLAGS, 32'h0, 1'b0);
        rd(OFS_ENABLES, 32'h0, 1'b0);
        chk(module_irq_request, 1'b0);
        $display("test mid-run reset done");
        report_and_stop();
    end

endmodule : ssf_top_tb_top
